// [common/nvmcs_pkg.sv]
package nvmcs_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CLKDIV = 8'h00;
  localparam logic [7:0] ADDR_INDEX = 8'h04;
  localparam logic [7:0] ADDR_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0C;
  localparam logic [7:0] ADDR_PPROT = 8'h10;
  localparam logic [7:0] ADDR_DPROT = 8'h14;
  localparam logic [7:0] ADDR_OBJECT = 8'h18;
  localparam logic [7:0] ADDR_TEST1 = 8'h1C;
  localparam logic [7:0] ADDR_TEST2 = 8'h20;
  localparam logic [7:0] ADDR_TEST3 = 8'h24;
  localparam logic [7:0] ADDR_TEST4 = 8'h28;
  localparam logic [7:0] ADDR_OPTION = 8'h2C;
  localparam logic [7:0] ADDR_TEST5 = 8'h30;
  localparam logic [7:0] ADDR_TEST6 = 8'h34;
  localparam logic [7:0] ADDR_TEST7 = 8'h38;
  localparam logic [7:0] ADDR_VERSION = 8'h3C;
  localparam logic [7:0] ADDR_INFO = 8'h40;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int DIVLD_BIT = 7;
  localparam int DONE_BIT = 7;
  localparam int BADSEQ_BIT = 5;
  localparam int PVIOL_BIT = 4;
  localparam int POPEN_BIT = 7;
  localparam int HDIS_BIT = 5;
  localparam int LDIS_BIT = 2;
  localparam int DOPEN_BIT = 7;
  localparam int OBJ_WORDS = 6;

  // ----------------------------------------------------------------
  // reset and fixed values
  // ----------------------------------------------------------------
  localparam logic [7:0] OPTION_FAULT = 8'hFF;
  localparam logic [7:0] PROT_RESET = 8'hFF;
  localparam logic [7:0] DPROT_RESET = 8'h8F;
  localparam logic [15:0] VERSION_WORD = 16'h0001;
  localparam logic [15:0] INFO_WORD = 16'h00A5;
  localparam logic [2:0] IDX_LAST = 3'h5;
  localparam logic [2:0] IDX_CMD = 3'h0;
  localparam logic [5:0] DIV_RESET = 6'h00;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_EV_ALL = 8'h01;
  localparam logic [7:0] CMD_EV_BLOCK = 8'h02;
  localparam logic [7:0] CMD_EV_PSECT = 8'h03;
  localparam logic [7:0] CMD_READ_ONCE = 8'h04;
  localparam logic [7:0] CMD_PROG_P = 8'h06;
  localparam logic [7:0] CMD_PROG_ONCE = 8'h07;
  localparam logic [7:0] CMD_ERASE_ALL = 8'h08;
  localparam logic [7:0] CMD_ERASE_BLK = 8'h09;
  localparam logic [7:0] CMD_ERASE_PSEC = 8'h0A;
  localparam logic [7:0] CMD_UNSECURE = 8'h0B;
  localparam logic [7:0] CMD_BACKDOOR = 8'h0C;
  localparam logic [7:0] CMD_USER_MARGIN = 8'h0D;
  localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0E;
  localparam logic [7:0] CMD_EV_DSECT = 8'h10;
  localparam logic [7:0] CMD_PROG_D = 8'h11;
  localparam logic [7:0] CMD_ERASE_DSEC = 8'h12;

  localparam logic [3:0] EXEC_CYCLES = 4'hF;

  typedef enum logic [1:0] {
    NVMCS_LOAD = 2'b00,
    NVMCS_IDLE = 2'b01,
    NVMCS_BUSY = 2'b10
  } nvmcs_state_t;

  // command handed to the array engine
  typedef struct packed {
    logic [7:0] code;
    logic [17:0] addr;
    logic [15:0] data0;
  } nvmcs_cmd_t;

endpackage

// [verilog/nvmcs_top.sv]
`timescale 1ns/1ps
// Summary of operation
// - word zero: code high byte, address 17:16 low; then address, data 0..3
// - seven factory test registers read zero and ignore writes
// - option register reads all eight bits, writes are ignored
// - option register loaded from the configuration byte during reset load
// - double-bit fault on that load sets option register to all ones
// - mode input governs divider and protection register writes
// - version word holds 4-bit number; zero and all ones mean none
// - information row readable only while resource select is active
// - a divider write while completion flag is one sets the divider-loaded flag, zero until then
// - program or erase without divider: not run, bad sequence set
// - while completion flag is zero, object writes and launches ignored
// - writing one to completion flag launches and passes code, address and data 0 on
// - completion flag stays zero until done, results land in object
// - verify-all, block verify always valid; others except erase-all, unsecure blocked in secured special mode
// - erase-all, unsecure special only; key normal only; field margin
// - erase-all needs all three program-array bits and data open bit
// - block erase needs the protection bits of the chosen array
// - program array writes one phrase, data array up to four words
// - one-time field written by program-once, read back by read-once
// - unsecure erases both arrays then verifies them
// - sector erase one sector; section verify counts units from start
// - unknown command code sets bad sequence and is not processed
// - object indices six and seven ignore writes and read zero
module nvmcs_top
  import nvmcs_pkg::*;
#(
  parameter int EXEC_CNT_W = 4
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // chip state and reset load
  input wire logic normal_chip_mode_i,
  input wire logic secured_i,
  input wire logic resource_select_i,
  input wire logic load_valid_i,
  input wire logic [7:0] option_bits_i,
  input wire logic load_dbl_fault_i,
  // array engine
  output nvmcs_cmd_t cmd_o,
  output logic cmd_start_o,
  input wire logic cmd_done_i,
  input wire logic [15:0] result_i,
  input wire logic result_we_i,
  input wire logic [2:0] result_idx_i,
  input wire logic prot_fault_i
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  nvmcs_state_t state;
  logic [15:0] obj [OBJ_WORDS];
  logic [2:0] obj_idx;
  logic [5:0] divider_value;
  logic divider_loaded_flag;
  logic [7:0] config_reg;
  logic [7:0] pprot;
  logic [7:0] dprot;
  logic [7:0] option_bits;
  logic bad_sequence_flag;
  logic protection_violation_flag;
  logic completion_flag;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire acc = psel_i & penable_i;
  wire wr = acc & pwrite_i;
  wire hit_div = paddr_i == ADDR_CLKDIV;
  wire hit_idx = paddr_i == ADDR_INDEX;
  wire hit_cfg = paddr_i == ADDR_CONFIG;
  wire hit_st = paddr_i == ADDR_STATE;
  wire hit_pp = paddr_i == ADDR_PPROT;
  wire hit_dp = paddr_i == ADDR_DPROT;
  wire hit_obj = paddr_i == ADDR_OBJECT;
  wire hit_opt = paddr_i == ADDR_OPTION;
  wire hit_ver = paddr_i == ADDR_VERSION;
  wire hit_inf = paddr_i == ADDR_INFO;
  wire hit_tst = (paddr_i == ADDR_TEST1) | (paddr_i == ADDR_TEST2) |
                 (paddr_i == ADDR_TEST3) | (paddr_i == ADDR_TEST4) |
                 (paddr_i == ADDR_TEST5) | (paddr_i == ADDR_TEST6) |
                 (paddr_i == ADDR_TEST7);
  wire mapped = hit_div | hit_idx | hit_cfg | hit_st | hit_pp | hit_dp |
                hit_obj | hit_opt | hit_ver | hit_inf | hit_tst;
  wire obj_impl = obj_idx <= IDX_LAST;
  // divider is write-once in normal mode, free in special mode
  wire div_ok = !normal_chip_mode_i | !divider_loaded_flag;
  wire idle = state == NVMCS_IDLE;
  wire launch = wr & hit_st & pwdata_i[DONE_BIT] & completion_flag
                & idle;

  // ----------------------------------------------------------------
  // command check
  // ----------------------------------------------------------------
  wire [7:0] code = obj[IDX_CMD][15:8];
  wire sec_special = secured_i & !normal_chip_mode_i;
  wire p_all_open = pprot[POPEN_BIT] & pprot[HDIS_BIT] & pprot[LDIS_BIT];
  wire d_open = dprot[DOPEN_BIT];
  logic known;
  logic mode_ok;
  logic writes;
  logic prot_ok;
  always_comb
  begin
    known = 1'b1;
    mode_ok = !sec_special;
    writes = 1'b1;
    prot_ok = 1'b1;
    case (code)
      CMD_EV_ALL, CMD_EV_BLOCK:
      begin
        mode_ok = 1'b1;
        writes = 1'b0;
      end
      CMD_EV_PSECT, CMD_EV_DSECT, CMD_READ_ONCE, CMD_USER_MARGIN:
        writes = 1'b0;
      CMD_PROG_P, CMD_PROG_D, CMD_PROG_ONCE, CMD_ERASE_PSEC,
      CMD_ERASE_DSEC: ;
      CMD_ERASE_BLK:
        // selection bit 1 set picks the program array
        prot_ok = obj[IDX_CMD][1] ? p_all_open : d_open;
      CMD_ERASE_ALL:
      begin
        mode_ok = !normal_chip_mode_i;
        prot_ok = p_all_open & d_open;
      end
      CMD_UNSECURE:
        mode_ok = !normal_chip_mode_i;
      CMD_BACKDOOR:
      begin
        mode_ok = normal_chip_mode_i;
        writes = 1'b0;
      end
      CMD_FIELD_MARGIN:
      begin
        mode_ok = !normal_chip_mode_i & !secured_i;
        writes = 1'b0;
      end
      default:
      begin
        known = 1'b0;
        writes = 1'b0;
      end
    endcase
  end
  wire reject = !known | !mode_ok
                | (writes & !divider_loaded_flag);
  wire prot_bad = !reject & !prot_ok;
  wire go = launch & !reject & prot_ok;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [31:0] rd_obj = obj_impl ? {16'h0000, obj[obj_idx]}
                                : 32'h0000_0000;
  wire [7:0] rd_state = {completion_flag, 1'b0, bad_sequence_flag,
                         protection_violation_flag, 4'h0};
  // holes, test words and an unselected row all fall through to zero
  wire [31:0] next_prdata =
    hit_div ? {24'h000000, divider_loaded_flag, 1'b0, divider_value} :
    hit_idx ? {29'h0000_0000, obj_idx} :
    hit_cfg ? {24'h000000, config_reg} :
    hit_st ? {24'h000000, rd_state} :
    hit_pp ? {24'h000000, pprot} :
    hit_dp ? {24'h000000, dprot} :
    hit_obj ? rd_obj :
    hit_opt ? {24'h000000, option_bits} :
    hit_ver ? {16'h0000, VERSION_WORD} :
    (hit_inf & resource_select_i) ? {16'h0000, INFO_WORD} :
    32'h0000_0000;

  // ----------------------------------------------------------------
  // apb answer: one wait state, pready on the second access cycle
  // ----------------------------------------------------------------
  logic ready_q;
  // the extra cycle lets the decode settle before data is registered
  wire next_ready = acc & !ready_q & !pready_o;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ready_q <= 1'b0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end
    else
    begin
      ready_q <= next_ready;
      pready_o <= next_ready;
      pslverr_o <= next_ready & !mapped;
      prdata_o <= next_prdata;
    end
  end
  wire wr_now = wr & ready_q;

  // ----------------------------------------------------------------
  // write strobes
  // ----------------------------------------------------------------
  wire in_busy = state == NVMCS_BUSY;
  wire wr_state = wr_now & hit_st;
  // launch outcomes, one per accepted write of the start bit
  wire launch_go = wr_now & launch & go;
  wire launch_bad = wr_now & launch & reject;
  wire launch_prot = wr_now & launch & prot_bad;
  // hardware set beats a software clear landing on the same edge
  wire clr_badseq = wr_state & pwdata_i[BADSEQ_BIT];
  wire clr_pviol = wr_state & pwdata_i[PVIOL_BIT];
  wire busy_pviol = in_busy & prot_fault_i;
  // divider frozen while a command runs: timebase must not shift
  wire div_we = wr_now & hit_div & div_ok & completion_flag;
  wire idx_we = wr_now & hit_idx;
  wire cfg_we = wr_now & hit_cfg;
  wire pp_we = wr_now & hit_pp;
  wire dp_we = wr_now & hit_dp;
  // object frozen from launch to done, so the engine sees one command
  wire obj_we = wr_now & hit_obj & obj_impl & completion_flag & idle;
  wire res_we = in_busy & result_we_i & (result_idx_i <= IDX_LAST);
  // normal mode: protection may only be added, bits only clear
  wire [7:0] next_pprot = normal_chip_mode_i ? (pprot & pwdata_i[7:0])
                                             : pwdata_i[7:0];
  wire [7:0] next_dprot = normal_chip_mode_i ? (dprot & pwdata_i[7:0])
                                             : pwdata_i[7:0];
  // a double-bit fault leaves every option bit set
  wire [7:0] next_option = load_dbl_fault_i ? OPTION_FAULT
                                            : option_bits_i;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic [EXEC_CNT_W-1:0] exec_cnt;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state <= NVMCS_LOAD;
      completion_flag <= 1'b0;
      option_bits <= OPTION_FAULT;
      cmd_start_o <= 1'b0;
      cmd_o <= '0;
      exec_cnt <= '0;
    end
    else
    begin
      cmd_start_o <= 1'b0;
      case (state)
        // nothing launches until the option byte has landed
        NVMCS_LOAD:
          if (load_valid_i)
          begin
            option_bits <= next_option;
            completion_flag <= 1'b1;
            state <= NVMCS_IDLE;
          end
        NVMCS_IDLE:
          if (launch_go)
          begin
            completion_flag <= 1'b0;
            cmd_o <= '{code: code, addr: {obj[IDX_CMD][1:0], obj[1]},
                       data0: obj[2]};
            cmd_start_o <= 1'b1;
            exec_cnt <= EXEC_CNT_W'(EXEC_CYCLES);
            state <= NVMCS_BUSY;
          end
        NVMCS_BUSY:
        begin
          // engine done alone ends the wait; the counter only counts down to zero
          if (exec_cnt != '0)
            exec_cnt <= exec_cnt - 1'b1;
          if (cmd_done_i)
          begin
            completion_flag <= 1'b1;
            state <= NVMCS_IDLE;
          end
        end
        default:
          state <= NVMCS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // error flags: hardware set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      bad_sequence_flag <= 1'b0;
      protection_violation_flag <= 1'b0;
    end
    else
    begin
      if (launch_bad)
        bad_sequence_flag <= 1'b1;
      else if (clr_badseq)
        bad_sequence_flag <= 1'b0;
      if (launch_prot | busy_pviol)
        protection_violation_flag <= 1'b1;
      else if (clr_pviol)
        protection_violation_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      divider_value <= DIV_RESET;
      divider_loaded_flag <= 1'b0;
      obj_idx <= IDX_CMD;
      config_reg <= 8'h00;
      pprot <= PROT_RESET;
      dprot <= DPROT_RESET;
    end
    else
    begin
      if (div_we)
      begin
        divider_value <= pwdata_i[5:0];
        divider_loaded_flag <= 1'b1;
      end
      // the index may move while busy; the object words and the divider are frozen
      if (idx_we)
        obj_idx <= pwdata_i[2:0];
      if (cfg_we)
        config_reg <= pwdata_i[7:0];
      if (pp_we)
        pprot <= next_pprot;
      if (dp_we)
        dprot <= next_dprot;
    end
  end

  // ----------------------------------------------------------------
  // command object
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < OBJ_WORDS; i++)
        obj[i] <= 16'h0000;
    end
    else
    begin
      if (obj_we)
        obj[obj_idx] <= pwdata_i[15:0];
      if (res_we)
        obj[result_idx_i] <= result_i;
    end
  end

endmodule

// [tb/nvmcs_top_monitor.sv]
`timescale 1ns/1ps
module nvmcs_top_monitor
  import nvmcs_pkg::*;
(
  // bus
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // engine
  input wire logic cmd_start_o,
  input wire logic cmd_done_i
);
  logic busy;
  logic rd;
  logic tst;
  logic go_w;
  assign rd = pready_o && !pwrite_i;
  assign tst = paddr_i inside {ADDR_TEST1, ADDR_TEST2, ADDR_TEST3,
    ADDR_TEST4, ADDR_TEST5, ADDR_TEST6, ADDR_TEST7};
  assign go_w = pready_o && pwrite_i && paddr_i == ADDR_STATE &&
    pwdata_i[DONE_BIT];
  // ---
  // busy as seen at the engine pins, conservative at both ends
  // ---
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      busy <= 1'b0;
    else if (cmd_start_o)
      busy <= 1'b1;
    else if (cmd_done_i)
      busy <= 1'b0;
  end
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  a_ready_wait: assert property ((psel_i && !penable_i) ##1
    (psel_i && penable_i) |=> pready_o) else $error("late ready");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready too long");
  a_err_clean: assert property (pslverr_o |-> pready_o &&
    (pwrite_i || prdata_o == 32'h0)) else $error("bad error reply");
  a_test_zero: assert property (rd && tst |-> prdata_o == 32'h0)
    else $error("test register not zero");
  a_version_ok: assert property (rd && paddr_i == ADDR_VERSION |->
    prdata_o[15:0] == VERSION_WORD && prdata_o[3:0] != 4'h0 &&
    prdata_o[3:0] != 4'hF) else $error("bad version word");
  a_start_cause: assert property (cmd_start_o |-> $past(go_w))
    else $error("start without launch");
  a_start_pulse: assert property (cmd_start_o |=> !cmd_start_o)
    else $error("start too long");
  a_start_idle: assert property (cmd_start_o |-> !busy)
    else $error("start while busy");
  a_busy_flag: assert property (rd && paddr_i == ADDR_STATE && busy
    |-> !prdata_o[DONE_BIT]) else $error("done while busy");
endmodule
bind nvmcs_top nvmcs_top_monitor u_mon (.clk_i, .rstn_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
  .pslverr_o, .cmd_start_o, .cmd_done_i);

// [tb/nvmcs_engine_model.sv]
`timescale 1ns/1ps
module nvmcs_engine_model
  import nvmcs_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // command side
  input wire nvmcs_cmd_t cmd_i,
  input wire logic cmd_start_i,
  input wire logic [7:0] delay_i,
  // answer side
  output logic cmd_done_o,
  output logic [15:0] result_o,
  output logic result_we_o,
  output logic [2:0] result_idx_o
);
  logic [7:0] cnt;
  logic busy;
  logic [15:0] res;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      busy <= 1'b0;
      cnt <= 8'h00;
      res <= 16'h0000;
    end
    else if (cmd_start_i && !busy)
    begin
      busy <= 1'b1;
      cnt <= delay_i;
      res <= cmd_i.data0 ^ 16'h5A5A;
    end
    else if (busy)
    begin
      cnt <= cnt - 8'h01;
      busy <= (cnt != 8'h00);
    end
  end
  // results land a cycle before done; delay must be one or more
  assign result_we_o = busy && (cnt == 8'h01);
  assign cmd_done_o = busy && (cnt == 8'h00);
  assign result_idx_o = 3'h2;
  // idle bus shows inverted data so stale words never match
  assign result_o = result_we_o ? res : ~res;
endmodule

// [tb/nvmcs_top_tb.sv]
`timescale 1ns/1ps
module nvmcs_top_tb;
  import nvmcs_pkg::*;
  localparam logic [5:0] DIV_SEL = 6'h13;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic normal_chip_mode_i = 1'b1;
  logic secured_i = 1'b0;
  logic resource_select_i = 1'b1;
  logic load_valid_i = 1'b0;
  logic [7:0] option_bits_i = 8'h00;
  logic load_dbl_fault_i = 1'b0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  nvmcs_cmd_t cmd_o;
  nvmcs_cmd_t got;
  logic cmd_start_o;
  logic cmd_done_i;
  logic [15:0] result_i;
  logic result_we_i;
  logic [2:0] result_idx_i;
  logic [7:0] delay = 8'h04;
  logic [7:0] obj_lo = 8'h00;
  logic [31:0] rd;
  logic err;
  logic [31:0] seed = 32'h0000004E;
  logic [15:0] obj [8];
  logic [7:0] tst_a [7] = '{8'h1C, 8'h20, 8'h24, 8'h28, 8'h30, 8'h34, 8'h38};
  logic [7:0] codes [19] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07,
    8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h10, 8'h11, 8'h12,
    8'h05, 8'h0F, 8'hFF};
  int n_mismatch = 0;
  int checked = 0;
  int n_start = 0;
  nvmcs_top dut (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .normal_chip_mode_i,
    .secured_i, .resource_select_i, .load_valid_i, .option_bits_i,
    .load_dbl_fault_i, .cmd_o, .cmd_start_o, .cmd_done_i, .result_i,
    .result_we_i, .result_idx_i, .prot_fault_i(1'b0));
  nvmcs_engine_model eng (.clk_i, .rstn_i, .cmd_i(cmd_o),
    .cmd_start_i(cmd_start_o), .delay_i(delay), .cmd_done_o(cmd_done_i),
    .result_o(result_i), .result_we_o(result_we_i),
    .result_idx_o(result_idx_i));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    if (cmd_start_o === 1'b1)
    begin
      got <= cmd_o;
      n_start <= n_start + 1;
    end
  end
  // ---
  // helpers
  // ---
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic ok(input logic [7:0] c, input logic nm,
    input logic sec);
    case (c)
      8'h01, 8'h02: ok = 1'b1;
      8'h08, 8'h0B: ok = !nm;
      8'h0C: ok = nm;
      8'h0E: ok = !nm && !sec;
      8'h03, 8'h04, 8'h06, 8'h07, 8'h09, 8'h0A, 8'h0D, 8'h10, 8'h11,
        8'h12: ok = nm || !sec;
      default: ok = 1'b0;
    endcase
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1)
      n_mismatch++;
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic await();
    int n;
    n = 0;
    do
    begin
      apb(1'b0, ADDR_STATE, 32'h0);
      n++;
    end while (rd[DONE_BIT] !== 1'b1 && n < 50);
    if (rd[DONE_BIT] !== 1'b1)
      n_mismatch++;
  endtask
  task automatic launch(input logic [7:0] c, input logic [1:0] ef);
    int s;
    s = n_start;
    delay = 8'(xs() % 30) + 8'd2;
    rdchk(ADDR_STATE, 32'h80);
    wr(ADDR_INDEX, 32'h0);
    wr(ADDR_OBJECT, {16'h0, c, obj_lo});
    wr(ADDR_STATE, 32'h80);
    await();
    chk({rd[BADSEQ_BIT], rd[PVIOL_BIT]}, ef);
    chk(32'(n_start - s), 32'(ef == 2'b00));
    wr(ADDR_STATE, 32'h30);
  endtask
  task automatic do_reset(input logic flt);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    load_valid_i <= 1'b0;
    load_dbl_fault_i <= flt;
    option_bits_i <= 8'(xs());
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    rdchk(ADDR_STATE, 32'h0);
    load_valid_i <= 1'b1;
    rdchk(ADDR_STATE, 32'h80);
    rdchk(ADDR_OPTION, flt ? 32'hFF : {24'h0, option_bits_i});
    rdchk(ADDR_CLKDIV, 32'h0);
  endtask
  task automatic conclude();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #600000;
    n_mismatch++;
    conclude();
  end
  // ---
  // main sequence
  // ---
  initial
  begin
    do_reset(1'b1);
    do_reset(1'b0);
    wr(ADDR_OPTION, 32'hFFFF);
    rdchk(ADDR_OPTION, {24'h0, option_bits_i});
    foreach (tst_a[i])
    begin
      wr(tst_a[i], xs());
      rdchk(tst_a[i], 32'h0);
    end
    rdchk(ADDR_VERSION, {16'h0, VERSION_WORD});
    rdchk(ADDR_INFO, {16'h0, INFO_WORD});
    resource_select_i <= 1'b0;
    rdchk(ADDR_INFO, 32'h0);
    resource_select_i <= 1'b1;
    apb(1'b0, 8'h7C, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test registers done");
    launch(CMD_PROG_P, 2'b10);
    wr(ADDR_CLKDIV, {26'h0, DIV_SEL});
    rdchk(ADDR_CLKDIV, {24'h0, 2'b10, DIV_SEL});
    wr(ADDR_CLKDIV, 32'h05);
    rdchk(ADDR_CLKDIV, {24'h0, 2'b10, DIV_SEL});
    normal_chip_mode_i <= 1'b0;
    wr(ADDR_CLKDIV, 32'h05);
    rdchk(ADDR_CLKDIV, 32'h85);
    normal_chip_mode_i <= 1'b1;
    $display("test divider done");
    for (int i = 0; i < 8; i++)
    begin
      obj[i] = (i != 0) ? 16'(xs()) : {CMD_EV_PSECT, 6'h0, 2'(xs())};
      wr(ADDR_INDEX, 32'(i));
      wr(ADDR_OBJECT, {16'h0, obj[i]});
    end
    for (int i = 0; i < 8; i++)
    begin
      wr(ADDR_INDEX, 32'(i));
      rdchk(ADDR_OBJECT, (i < 6) ? {16'h0, obj[i]} : 32'h0);
    end
    delay = 8'd40;
    wr(ADDR_INDEX, 32'h3);
    wr(ADDR_STATE, 32'h80);
    wr(ADDR_OBJECT, 32'hBEEF);
    rdchk(ADDR_STATE, 32'h0);
    wr(ADDR_STATE, 32'h80);
    chk(32'(got.code), 32'(CMD_EV_PSECT));
    chk(32'(got.addr), {14'h0, obj[0][1:0], obj[1]});
    chk(32'(got.data0), 32'(obj[2]));
    await();
    rdchk(ADDR_OBJECT, {16'h0, obj[3]});
    wr(ADDR_INDEX, 32'h2);
    rdchk(ADDR_OBJECT, {16'h0, obj[2] ^ 16'h5A5A});
    chk(32'(n_start), 32'h1);
    wr(ADDR_STATE, 32'h30);
    $display("test object done");
    for (int m = 0; m < 4; m++)
    begin
      normal_chip_mode_i <= m[0];
      secured_i <= m[1];
      foreach (codes[k])
        launch(codes[k], {!ok(codes[k], m[0], m[1]), 1'b0});
    end
    $display("test modes done");
    normal_chip_mode_i <= 1'b1;
    secured_i <= 1'b0;
    wr(ADDR_PPROT, 32'h0);
    wr(ADDR_PPROT, 32'hFF);
    rdchk(ADDR_PPROT, 32'h0);
    obj_lo = 8'h02;
    launch(CMD_ERASE_BLK, 2'b01);
    obj_lo = 8'h00;
    launch(CMD_ERASE_BLK, 2'b00);
    normal_chip_mode_i <= 1'b0;
    launch(CMD_ERASE_ALL, 2'b01);
    wr(ADDR_PPROT, 32'hFF);
    rdchk(ADDR_PPROT, 32'hFF);
    wr(ADDR_DPROT, 32'h0F);
    launch(CMD_ERASE_ALL, 2'b01);
    wr(ADDR_DPROT, 32'h8F);
    launch(CMD_ERASE_ALL, 2'b00);
    $display("test protection done");
    conclude();
  end
endmodule
